// [pkg/sac_pkg.sv]
// Shared constants and types for the SAR conversion controller.
// Assumes a 250 MHz system clock; analog parts live outside the block.
package sac_pkg;
    localparam int          CLK_PERIOD_PS     = 4000;
    localparam int          RES_BITS          = 8;
    localparam int          TRIAL_NS          = 3000;
    localparam int          TRIAL_CYC         = (TRIAL_NS * 1000) / CLK_PERIOD_PS;
    localparam int          DATA_EN_NS        = 500;
    localparam int          DATA_EN_CYC       = (DATA_EN_NS * 1000) / CLK_PERIOD_PS;
    localparam int          BLANK_NS          = 1500;
    localparam int          BLANK_CYC         = (BLANK_NS * 1000) / CLK_PERIOD_PS;
    localparam int          CLEAR_NS          = 2000;
    localparam int          CLEAR_CYC         = (CLEAR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          DRIVE_DLY_CYC     = 2;
    localparam logic [7:0]  SAR_RESET         = 8'h00;
    localparam logic [7:0]  MSB_MASK          = 8'h80;

    typedef enum {
        SAC_IDLE,
        SAC_TRIAL,
        SAC_DONE,
        SAC_HALT
    } sac_state_t;

    // Result pin group: three-state data and ready flag
    typedef struct packed {
        logic [7:0] data;
        logic       data_oe;
        logic       result_valid_n;
    } sac_result_t;
endpackage

// [hw/sac_divider.sv]
// Trial-rate enable divider for the SAR controller.
// Assumes synchronous active-high reset on the same clock.
`timescale 1ns/1ps
module sac_divider
    import sac_pkg::*;
#(
    parameter int DIV = TRIAL_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control
    input  wire logic run,
    output logic      tick
);
    // Refuse a divider that cannot produce a one-cycle pulse
    if (DIV < 2) begin : g_bad_div
        $error("sac_divider: DIV must be at least 2");
    end

    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_tick;

    always_comb begin
        next_cnt  = cnt;
        next_tick = 1'b0;
        if (!run) begin
            next_cnt = '0;
        end else if (cnt == CW'(DIV - 1)) begin
            next_cnt  = '0;
            next_tick = 1'b1;
        end else begin
            next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule // sac_divider

// [hw/sac_core.sv]
// SAR conversion controller: sequencing, result pins and blanking.
// Assumes an external comparator and DAC; comparator and control pin are asynchronous.
`timescale 1ns/1ps
module sac_core
    import sac_pkg::*;
#(
    parameter int TRIAL  = TRIAL_CYC,
    parameter int BLANK  = BLANK_CYC,
    parameter int CLEAR  = CLEAR_CYC
) (
    // Clock and reset
    input  wire logic       CLOCK,
    input  wire logic       RST,
    // Controller side
    input  wire logic       BLANK_CONVERT_N,
    input  wire logic       BIPOLAR_OFFSET,
    // Analog front end
    input  wire logic       COMP_DAC_LOW,
    output logic [7:0]      DAC_CODE,
    output logic            OFFSET_SWITCH,
    // Result pins
    output logic [7:0]      DATA_OUT,
    output logic            DATA_OE,
    output logic            RESULT_VALID_N
);
    // Comparator answer needs its sync delay inside one trial; hi_cnt saturates at 1023
    if (BLANK < 1 || CLEAR <= BLANK || CLEAR >= 1023 || TRIAL < 4 ||
        DRIVE_DLY_CYC > 3 || DRIVE_DLY_CYC >= DATA_EN_CYC) begin : g_bad_timing
        $error("sac_core: timing parameters out of range");
    end

    // Input synchronisers
    logic [1:0] bc_sync;
    logic [1:0] cmp_sync;
    logic [1:0] bip_sync;
    wire        bc_high  = bc_sync[1];
    wire        cmp_low  = cmp_sync[1];

    sac_state_t  state;
    sac_state_t  next_state;
    logic [7:0]  sar;
    logic [7:0]  next_sar;
    logic [7:0]  trial;
    logic [7:0]  next_trial;
    sac_result_t res;
    sac_result_t next_res;
    logic [9:0]  hi_cnt;
    logic [9:0]  next_hi_cnt;
    logic [1:0]  oe_dly;
    logic [1:0]  next_oe_dly;
    logic        tick;

    // Trial decision: keep or drop the bit under test
    function automatic logic [7:0] decide_bit(input logic [7:0] code, input logic [7:0] mask,
                                              input logic keep);
        return keep ? code : (code & ~mask);
    endfunction

    sac_divider #(
        .DIV (TRIAL)
    ) u_div (
        .clk  (CLOCK),
        .rst  (RST),
        .run  (state == SAC_TRIAL),
        .tick (tick)
    );

    always_comb begin
        next_state  = state;
        next_sar    = sar;
        next_trial  = trial;
        next_res    = res;
        next_oe_dly = oe_dly;
        next_hi_cnt = bc_high ? ((hi_cnt == 10'h3FF) ? hi_cnt : hi_cnt + 10'h001) : 10'h000;
        case (state)
            SAC_IDLE: begin
                if (!bc_high) begin
                    // Result pins left as they are on start; DAC_CODE moves to MSB_MASK
                    next_state = SAC_TRIAL;
                    next_sar   = MSB_MASK;
                    next_trial = MSB_MASK;
                end
            end
            SAC_TRIAL: begin
                if (bc_high) begin
                    next_state = SAC_HALT;
                end else if (tick) begin
                    // Keep trial bit only while DAC sum below input
                    next_sar = decide_bit(sar, trial, cmp_low);
                    if (trial[0]) begin
                        next_state         = SAC_DONE;
                        next_res.data      = decide_bit(sar, trial, cmp_low);
                        next_res.result_valid_n = 1'b0;
                        next_oe_dly        = 2'(DRIVE_DLY_CYC);
                    end else begin
                        next_trial = trial >> 1;
                        next_sar   = decide_bit(sar, trial, cmp_low) | (trial >> 1);
                    end
                end
            end
            SAC_DONE: begin
                if (oe_dly != 2'h0) begin
                    next_oe_dly = oe_dly - 2'h1;
                end else begin
                    next_res.data_oe = 1'b1;
                end
                if (bc_high && hi_cnt == 10'(BLANK - 1)) begin
                    // Blank outputs and re-arm
                    next_res.result_valid_n = 1'b1;
                    next_res.data_oe        = 1'b0;
                    next_sar                = SAR_RESET;
                    next_state              = SAC_HALT;
                end
            end
            SAC_HALT: begin
                if (bc_high && hi_cnt == 10'(BLANK - 1)) begin
                    next_res.result_valid_n = 1'b1;
                    next_res.data_oe        = 1'b0;
                end
                if (!bc_high) begin
                    // Short pulse keeps old data; long pulse restarts
                    if (hi_cnt >= 10'(CLEAR)) begin
                        next_state = SAC_TRIAL;
                        next_sar   = MSB_MASK;
                        next_trial = MSB_MASK;
                    end
                end
            end
            default: next_state = SAC_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            bc_sync  <= 2'h3;
            cmp_sync <= 2'h0;
            bip_sync <= 2'h0;
            state    <= SAC_IDLE;
            sar      <= SAR_RESET;
            trial    <= MSB_MASK;
            res      <= '{data: 8'h00, data_oe: 1'b0, result_valid_n: 1'b1};
            oe_dly   <= 2'h0;
            hi_cnt   <= 10'h000;
        end else begin
            bc_sync  <= {bc_sync[0], BLANK_CONVERT_N};
            cmp_sync <= {cmp_sync[0], COMP_DAC_LOW};
            bip_sync <= {bip_sync[0], BIPOLAR_OFFSET};
            state    <= next_state;
            sar      <= next_sar;
            trial    <= next_trial;
            res      <= next_res;
            oe_dly   <= next_oe_dly;
            hi_cnt   <= next_hi_cnt;
        end
    end

    assign DAC_CODE       = sar;
    assign OFFSET_SWITCH  = bip_sync[1];
    assign DATA_OUT       = res.data;
    assign DATA_OE        = res.data_oe;
    assign RESULT_VALID_N = res.result_valid_n;

    // Assertions
    a_ready_then_drive: assert property (@(posedge CLOCK) disable iff (RST)
        $fell(RESULT_VALID_N) |-> ##[1:4] DATA_OE)
        else $error("data not driven after ready");
    a_start_holds_pins: assert property (@(posedge CLOCK) disable iff (RST)
        ((state == SAC_IDLE || state == SAC_HALT) && !bc_high) |=> $stable(RESULT_VALID_N) && $stable(DATA_OE))
        else $error("start changed result pins");
    a_msb_first: assert property (@(posedge CLOCK) disable iff (RST)
        (state != SAC_TRIAL ##1 state == SAC_TRIAL) |-> trial == MSB_MASK && DAC_CODE == MSB_MASK)
        else $error("trial did not start at msb");
    a_keep_bit: assert property (@(posedge CLOCK) disable iff (RST)
        (state == SAC_TRIAL && tick && !bc_high && cmp_low) |=> (sar & $past(trial)) != 8'h00)
        else $error("kept bit cleared");
    a_drop_bit: assert property (@(posedge CLOCK) disable iff (RST)
        (state == SAC_TRIAL && tick && !bc_high && !cmp_low) |=> (sar & $past(trial)) == 8'h00)
        else $error("rejected bit kept");
    a_result_latched: assert property (@(posedge CLOCK) disable iff (RST)
        $fell(RESULT_VALID_N) |-> DATA_OUT == DAC_CODE && $past(trial) == 8'h01)
        else $error("result not latched");
    a_blank_release: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(RESULT_VALID_N) |-> !DATA_OE && sar == SAR_RESET)
        else $error("outputs not blanked");
    a_halt_keeps_ready: assert property (@(posedge CLOCK) disable iff (RST)
        (state == SAC_TRIAL && bc_high) |=> $stable(RESULT_VALID_N) && $stable(DATA_OUT))
        else $error("halt changed outputs");
    a_offset_follows: assert property (@(posedge CLOCK) disable iff (RST)
        (!$past(RST) && !$past(RST, 2)) |-> OFFSET_SWITCH == $past(BIPOLAR_OFFSET, 2))
        else $error("offset switch wrong");
    a_trial_pace: assert property (@(posedge CLOCK) disable iff (RST)
        (state == SAC_TRIAL && $past(state) == SAC_TRIAL && $changed(trial)) |-> $past(tick))
        else $error("trial advanced off pace");
    a_drive_needs_ready: assert property (@(posedge CLOCK) disable iff (RST)
        DATA_OE |-> !RESULT_VALID_N)
        else $error("data driven without ready");
    a_short_pulse_halts: assert property (@(posedge CLOCK) disable iff (RST)
        (state == SAC_HALT && !bc_high && hi_cnt < 10'(CLEAR)) |=> state == SAC_HALT)
        else $error("short pulse restarted conversion");

    c_conversion_done: cover property (@(posedge CLOCK) $fell(RESULT_VALID_N));
    c_blank: cover property (@(posedge CLOCK) $rose(RESULT_VALID_N));
    c_halt: cover property (@(posedge CLOCK) state == SAC_TRIAL ##1 state == SAC_HALT);
    c_restart: cover property (@(posedge CLOCK) state == SAC_HALT ##1 state == SAC_TRIAL);
    c_short_pulse: cover property (@(posedge CLOCK) state == SAC_HALT && !bc_high && hi_cnt < 10'(CLEAR));
endmodule // sac_core

// [verif/sac_front_model.sv]
// Analog front end model: ideal comparator against a code-valued input level.
// Assumes the controller samples the comparator through its own synchronizer.
`timescale 1ns/1ps
module sac_front_model
    import sac_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Input level as an ideal code
    input  wire logic [7:0] level,
    // Trial code from the controller
    input  wire logic [7:0] dac_code,
    output logic            dac_low = 1'b0
);
    // Registered so the answer trails each new trial code, like a settling comparator
    always @(posedge clk) begin
        dac_low <= (dac_code <= level);
    end
endmodule // sac_front_model

// [verif/sac_core_tb.sv]
// Self-checking bench for the SAR conversion controller.
// Assumes shortened trial, blank and clear counts; comparator from the front model.
`timescale 1ns/1ps
module sac_core_tb;
    import sac_pkg::*;
    localparam int T_TRIAL = 4;
    localparam int T_BLANK = 3;
    localparam int T_CLEAR = 5;
    logic       clock  = 1'b0;
    logic       rst    = 1'b1;
    logic       bc_n   = 1'b1;
    logic       bip    = 1'b0;
    logic       comp;
    logic [7:0] vin    = 8'h00;
    logic [7:0] dac;
    logic       offset_sw;
    logic [7:0] data;
    logic       oe;
    logic       valid_n;
    int         failures = 0;
    int         checked  = 0;
    logic [7:0] codes [4] = '{8'hA5, 8'h00, 8'hFF, 8'h80};

    always #2 clock = ~clock;

    sac_core #(.TRIAL(T_TRIAL), .BLANK(T_BLANK), .CLEAR(T_CLEAR)) i_sac_core (
        .CLOCK(clock), .RST(rst), .BLANK_CONVERT_N(bc_n), .BIPOLAR_OFFSET(bip),
        .COMP_DAC_LOW(comp), .DAC_CODE(dac), .OFFSET_SWITCH(offset_sw),
        .DATA_OUT(data), .DATA_OE(oe), .RESULT_VALID_N(valid_n));

    sac_front_model i_sac_front_model (.clk(clock), .level(vin), .dac_code(dac), .dac_low(comp));

    task automatic finish_test;
        $display("Counts: checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait for ready (sel_oe 0) or drive enable (sel_oe 1) to reach a level
    task automatic wait_lvl(input logic sel_oe, input logic v, input int bound, output int n);
        n = 0;
        while ((sel_oe ? oe : valid_n) !== v) begin
            @(posedge clock);
            #1;
            n++;
            if (n > bound) begin
                failures++;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, sel_oe ? oe : valid_n, v);
                finish_test();
            end
        end
    endtask

    task automatic convert(input logic [7:0] code);
        int n;
        vin <= code;
        @(posedge clock);
        bc_n <= 1'b0;
        repeat (6) @(posedge clock);
        #1;
        check8({6'h00, valid_n, oe}, 8'h02);
        wait_lvl(1'b0, 1'b0, 3 + 9 * T_TRIAL + 10, n);
        // Sync 2, entry 1, one tick lag, then T_TRIAL per bit; 6 cycles already waited
        check8(8'(n), 8'(8 * T_TRIAL - 2));
        check8({7'h00, oe}, 8'h00);
        wait_lvl(1'b1, 1'b1, DATA_EN_CYC, n);
        check8(data, code);
        @(posedge clock);
        bc_n <= 1'b1;
        wait_lvl(1'b0, 1'b1, T_BLANK + 8, n);
        check8({7'h00, n >= T_BLANK}, 8'h01);
        check8({7'h00, oe}, 8'h00);
        repeat (T_CLEAR + 3) @(posedge clock);
    endtask

    task automatic halt_test;
        vin <= 8'h3C;
        @(posedge clock);
        bc_n <= 1'b0;
        repeat (12) @(posedge clock);
        bc_n <= 1'b1;
        repeat (3) @(posedge clock);
        bc_n <= 1'b0;
        repeat (60) @(posedge clock);
        #1;
        check8({6'h00, valid_n, oe}, 8'h02);
        check8(data, 8'h80);
        @(posedge clock);
        bc_n <= 1'b1;
        repeat (T_CLEAR + 3) @(posedge clock);
        convert(8'h3C);
        $display("Test halt and restart done");
    endtask

    task automatic bipolar_test;
        @(posedge clock);
        bip <= 1'b1;
        repeat (5) @(posedge clock);
        #1;
        check8({7'h00, offset_sw}, 8'h01);
        @(posedge clock);
        bip <= 1'b0;
        repeat (5) @(posedge clock);
        #1;
        check8({7'h00, offset_sw}, 8'h00);
        $display("Test bipolar offset done");
    endtask

    initial begin
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        foreach (codes[i]) begin
            convert(codes[i]);
        end
        $display("Test conversions done");
        halt_test();
        bipolar_test();
        finish_test();
    end
endmodule // sac_core_tb
